// file: dla_config.sv
`timescale 1ns/1ps
module dla_config (
	input wire logic clk, // 100 MHz bus interface clock
	input wire logic resetn, // system reset, active low
	input wire dla_pkg::dla_req_t req, // backplane access
	input wire logic modId, // this slot's select line, active high
	input wire logic [dla_pkg::ENTITIES-1:0][7:0] selector, // straps
	input wire logic [dla_pkg::ENTITIES-1:0][7:0] devCount, // group sizes
	output dla_pkg::dla_ans_t ans, // acknowledge and read data
	output logic selfTestGo, // count loaded, self-test may run
	output logic [dla_pkg::ENTITIES-1:0][7:0] logAddr // active addresses
);
	// hard-wired low bit count for a group of d devices
	function automatic logic [3:0] hardBits(input logic [7:0] d);
		logic [3:0] h;
		h = 4'h0;
		if (d == dla_pkg::CNT_SINGLE_A || d == dla_pkg::CNT_SINGLE_B ||
				d == dla_pkg::CNT_SINGLE_C) begin
			h = 4'h0;
		end else if (d > 8'h80) begin
			h = 4'h8;
		end else begin
			for (int i = 7; i >= 1; i--) begin
				if (d <= 8'(1 << i)) begin
					h = 4'(i);
				end
			end
		end
		return h;
	endfunction

	// mask of hard-wired bits
	function automatic logic [7:0] hardMask(input logic [7:0] d);
		logic [8:0] m;
		m = (9'h001 << hardBits(d)) - 9'h001;
		return m[7:0];
	endfunction

	dla_pkg::dla_state_t state_q, state_d;
	logic [dla_pkg::ENTITIES-1:0][7:0] la_q, la_d;
	logic [dla_pkg::ENTITIES-1:0][7:0] cnt_q, cnt_d;
	logic [dla_pkg::ENTITIES-1:0] dyn_q, dyn_d;
	dla_pkg::dla_ans_t ans_q, ans_d;
	logic go_q, go_d;
	logic [dla_pkg::ENTITIES-1:0] hit;
	logic [dla_pkg::ENTITIES-1:0] atTop;
	logic inPage;
	logic [7:0] reqLa;
	logic [5:0] reqOfs;

	assign inPage = (req.addr[15:14] == dla_pkg::CFG_BASE[15:14]);
	assign reqLa = req.addr[dla_pkg::LA_SHIFT +: 8];
	assign reqOfs = req.addr[dla_pkg::LA_SHIFT-1:0];

	// per-entity decode; only the first entity still at 255 shows there
	generate
		for (genvar e = 0; e < dla_pkg::ENTITIES; e++) begin : g_dec
			logic [7:0] m;
			logic [7:0] idx;
			assign m = hardMask(cnt_q[e]);
			assign idx = reqLa & m;
			assign atTop[e] = (la_q[e] == dla_pkg::LA_DYNAMIC);
			always_comb begin
				hit[e] = 1'b0;
				if (atTop[e]) begin
					hit[e] = modId && reqLa == dla_pkg::LA_DYNAMIC &&
						((atTop & dla_pkg::ENTITIES'((1 << e) - 1)) == '0);
				end else if ((reqLa & ~m) == (la_q[e] & ~m)) begin
					hit[e] = (m == 8'h00) || (idx < cnt_q[e]);
				end
			end
		end
	endgenerate

	// access sequencing and address register updates
	always_comb begin
		state_d = state_q;
		la_d = la_q;
		cnt_d = cnt_q;
		dyn_d = dyn_q;
		ans_d = ans_q;
		go_d = go_q;
		case (state_q)
			dla_pkg::ST_LOAD: begin
				cnt_d = devCount;
				go_d = 1'b1;
				state_d = dla_pkg::ST_IDLE;
			end
			dla_pkg::ST_IDLE: begin
				ans_d.dtack = 1'b0;
				if (req.strobe && inPage && |hit) begin
					state_d = dla_pkg::ST_ACK;
					ans_d.dtack = 1'b1;
					ans_d.rdata = dla_pkg::READ_IDLE;
					for (int e = dla_pkg::ENTITIES - 1; e >= 0; e--) begin
						if (hit[e] && !req.write &&
								reqOfs == dla_pkg::OFS_DEC_COUNT) begin
							ans_d.rdata = {8'h00, cnt_q[e]};
						end
					end
					for (int e = 0; e < dla_pkg::ENTITIES; e++) begin
						// moved on this edge, the same edge that raises the ack
						if (hit[e] && req.write && dyn_q[e] &&
								reqOfs == dla_pkg::OFS_ADDR_ASSIGN) begin
							la_d[e] = req.wdata[dla_pkg::LA_MSB:0] &
								~hardMask(cnt_q[e]);
						end
					end
				end
			end
			dla_pkg::ST_ACK: begin
				// hold acknowledge until master drops the strobe
				if (!req.strobe) begin
					ans_d.dtack = 1'b0;
					state_d = dla_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = dla_pkg::ST_IDLE;
				ans_d.dtack = 1'b0;
			end
		endcase
	end

	// registers; straps are sampled while reset is held
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= dla_pkg::ST_LOAD;
			la_q <= selector;
			for (int e = 0; e < dla_pkg::ENTITIES; e++) begin
				dyn_q[e] <= (selector[e] == dla_pkg::LA_DYNAMIC);
			end
			cnt_q <= '0;
			ans_q <= '0;
			go_q <= 1'b0;
		end else begin
			state_q <= state_d;
			la_q <= la_d;
			cnt_q <= cnt_d;
			dyn_q <= dyn_d;
			ans_q <= ans_d;
			go_q <= go_d;
		end
	end

	assign ans = ans_q;
	assign selfTestGo = go_q;
	assign logAddr = la_q;
endmodule

// file: dla_pkg.sv
package dla_pkg;
	// configuration space sits in the 16-bit short address page
	localparam logic [15:0] CFG_BASE = 16'hc000;
	localparam int LA_SHIFT = 6; // 64 bytes of registers per address
	localparam logic [5:0] OFS_ADDR_ASSIGN = 6'h00;
	localparam logic [5:0] OFS_DEC_COUNT = 6'h06;
	localparam int LA_MSB = 7; // address field bits 7..0
	localparam logic [7:0] LA_DYNAMIC = 8'hff;
	localparam logic [7:0] CNT_SINGLE_A = 8'h00;
	localparam logic [7:0] CNT_SINGLE_B = 8'h01;
	localparam logic [7:0] CNT_SINGLE_C = 8'hff;
	localparam logic [15:0] READ_IDLE = 16'h0000;
	localparam int ENTITIES = 2; // independently decoded entities

	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_IDLE = 2'b01,
		ST_ACK = 2'b10
	} dla_state_t;

	// one access from the backplane, held by the master until acked
	typedef struct packed {
		logic strobe;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dla_req_t;

	// the slave's answer
	typedef struct packed {
		logic dtack;
		logic [15:0] rdata;
	} dla_ans_t;
endpackage

// file: dla_config_properties.sv
`timescale 1ns/1ps
module dla_config_properties (
	input wire logic clk, // bus clock
	input wire logic resetn, // reset, active low
	input wire dla_pkg::dla_req_t req, // access
	input wire logic modId, // slot select
	input wire logic [1:0][7:0] selector, // straps
	input wire logic [1:0][7:0] devCount, // group sizes
	input wire dla_pkg::dla_ans_t ans, // answer
	input wire logic selfTestGo, // counts loaded
	input wire logic [1:0][7:0] logAddr // addresses
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// idle slave sees a request inside its moved pair of addresses
	sequence hitOwn;
		req.strobe && !ans.dtack && logAddr[0] != 8'hff
			&& devCount[0] == 8'h02
			&& req.addr[15:7] == {2'h3, logAddr[0][7:1]};
	endsequence
	own_decode_a: assert property (hitOwn |=> ans.dtack)
		else $error("no ack at own address");
	no_select_a: assert property (
		req.strobe && !modId && req.addr[13:6] == 8'hff |=> !ans.dtack)
		else $error("ack without select");
	move_first_a: assert property (
		$rose(ans.dtack) && req.write && req.addr == 16'hffc0
		&& $past(logAddr[0]) == 8'hff && devCount[0] == 8'h02
		|-> logAddr[0] == {req.wdata[7:1], 1'h0}) else $error("late move");
	ack_hold_a: assert property (ans.dtack && req.strobe |=> ans.dtack)
		else $error("ack dropped early");
	ack_drop_a: assert property (
		ans.dtack && !req.strobe |=> !ans.dtack) else $error("ack stuck");
	reset_load_a: assert property (
		$rose(resetn) |-> logAddr == selector) else $error("no reload");
	count_go_a: assert property ($rose(resetn) |=> selfTestGo)
		else $error("self-test not released");
	fixed_addr_a: assert property (
		selector[1] != 8'hff |-> logAddr[1] == selector[1])
		else $error("fixed address moved");
endmodule
bind dla_config dla_config_properties u_chk (.clk(clk), .resetn(resetn),
	.req(req), .modId(modId), .selector(selector), .devCount(devCount),
	.ans(ans), .selfTestGo(selfTestGo), .logAddr(logAddr));

// file: dla_rm.sv
`timescale 1ns/1ps
module dla_rm (
	input wire logic clk, // bus clock
	output dla_pkg::dla_req_t req, // access to the slave
	input wire dla_pkg::dla_ans_t ans // slave answer
);
	logic [15:0] q; // last read data
	logic [15:0] ok; // 1 acked, 0 bus error
	initial req = '0;
	// released lines show inverted values, not the last ones
	task automatic x(input logic w, input logic [15:0] a, d);
		@(negedge clk);
		req <= '{1'h1, w, a, d};
		ok = 16'h0;
		for (int i = 0; i < 20 && ok == 16'h0; i++) begin
			@(posedge clk);
			if (ans.dtack === 1'h1) begin
				ok = 16'h1;
				q = ans.rdata;
			end
		end
		@(negedge clk);
		req <= '{1'h0, ~w, ~a, ~d};
		@(posedge clk);
	endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk = 1'h0;
	logic resetn = 1'h0;
	logic modId = 1'h0;
	logic [1:0][7:0] selector = 16'hffff;
	logic [1:0][7:0] devCount = 16'h0102;
	dla_pkg::dla_req_t req;
	dla_pkg::dla_ans_t ans;
	logic selfTestGo;
	logic [1:0][7:0] logAddr;
	int mismatches = 0;
	int n_checks = 0;
	initial begin
		forever #5 clk = ~clk;
	end
	dla_config u_dla_config (.clk(clk), .resetn(resetn), .req(req),
		.modId(modId), .selector(selector), .devCount(devCount),
		.ans(ans), .selfTestGo(selfTestGo), .logAddr(logAddr));
	dla_rm rm (.clk(clk), .req(req), .ans(ans));
	task automatic chk(input logic [15:0] g, e);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// straps only change while reset is held
	task automatic rst(input logic [7:0] s1);
		@(negedge clk);
		resetn <= 1'h0;
		selector[1] <= s1;
		repeat (16) @(negedge clk);
		resetn <= 1'h1;
		@(negedge clk);
		chk(logAddr, {s1, 8'hff});
		chk({15'h0, selfTestGo}, 16'h1);
	endtask
	// entities show up at 255 one by one under the slot select
	task automatic t_find;
		rm.x(1'h0, 16'hffc6, 16'h0);
		chk(rm.ok, 16'h0);
		@(negedge clk) modId <= 1'h1;
		rm.x(1'h0, 16'hffc6, 16'h0);
		chk(rm.q, 16'h0002);
		rm.x(1'h1, 16'hffc0, 16'hab13);
		chk(logAddr, 16'hff12);
		rm.x(1'h0, 16'hffc6, 16'h0);
		chk(rm.q, 16'h0001);
		rm.x(1'h1, 16'hffc0, 16'h0040);
		chk(logAddr, 16'h4012);
		rm.x(1'h0, 16'hffc6, 16'h0);
		chk(rm.ok, 16'h0);
	endtask
	// moved group decodes without select, old block goes quiet
	task automatic t_move;
		@(negedge clk) modId <= 1'h0;
		rm.x(1'h0, 16'hc4c0, 16'h0);
		chk(rm.ok, 16'h1);
		rm.x(1'h1, 16'hc4c0, 16'h0021);
		chk(logAddr, 16'h4020);
		rm.x(1'h0, 16'hc480, 16'h0);
		chk(rm.ok, 16'h0);
		rm.x(1'h0, 16'hc880, 16'h0);
		chk(rm.ok, 16'h0);
	endtask
	// a strapped address ignores writes to its assignment register
	task automatic t_fixed;
		rm.x(1'h1, 16'hc140, 16'h0033);
		chk(rm.ok, 16'h1);
		chk(logAddr, 16'h05ff);
	endtask
	initial begin
		rst(8'hff);
		t_find;
		t_move;
		rst(8'h05);
		t_fixed;
		conclude;
	end
	// watchdog well beyond the roughly 150 cycles the tests need
	initial begin
		#20000;
		mismatches++;
		conclude;
	end
endmodule
